// File: src/prc_regs.svh
// Constants for the port 0 reference clock select block.
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
`define PRC_MODE_MII_MAC       2'h0
`define PRC_MODE_MII_PHY       2'h1
`define PRC_MODE_RMII_MAC      2'h2
`define PRC_MODE_RMII_PHY      2'h3
`define PRC_MODE_RESET         2'h3
`define PRC_RMII_CLK_MHZ       50
`define PRC_SYS_CLK_MHZ        100
`define PRC_REFCLK_DIV_HALF    (`PRC_SYS_CLK_MHZ / (2 * `PRC_RMII_CLK_MHZ))
`define PRC_HEARTBEAT_W        6
`define PRC_STRAP_SETTLE       2'h2
`endif

// File: src/prc_pkg.sv
// Types for the port 0 reference clock select block.
package prc_pkg;
  typedef enum logic [1:0] {
    PRC_MII_MAC  = 2'b00,
    PRC_MII_PHY  = 2'b01,
    PRC_RMII_MAC = 2'b10,
    PRC_RMII_PHY = 2'b11
  } prc_mode_t;

  typedef struct packed {
    logic out_en;
    logic in_en;
    logic pulldown_en;
  } prc_pad_t;
endpackage

// File: src/prc_sync.sv
// Two-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module prc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
    if (i_rst) begin
      nxt_meta = '0;
      nxt_sync = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

// File: src/prc_port0_refclk_select.sv
// Port 0 MII/RMII clock pin direction, pad enables and mode strap capture.
`timescale 1ns/1ps
`default_nettype none
`include "prc_regs.svh"
module prc_port0_refclk_select
  import prc_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_port0_link_clock,
  input  wire logic i_port0_mode_strap_bit0,
  input  wire logic i_port0_mode_strap_bit1,
  input  wire logic i_virtual_phy_isolate,
  input  wire logic i_rmii_clock_dir_out,
  output logic      o_port0_clk_out,
  output logic      o_port0_clk_oe,
  output logic      o_port0_clk_in_en,
  output logic      o_port0_clk_pd_en,
  output logic [1:0] o_mode,
  output logic      o_link_clock_alive
);
  // Strap pins and control bits come from outside this clock domain. Each one
  // passes two flops before any decode reads it.
  logic [3:0] sync_in;
  prc_sync #(.W(4)) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_port0_mode_strap_bit1, i_port0_mode_strap_bit0,
               i_virtual_phy_isolate, i_rmii_clock_dir_out}),
    .o_sync  (sync_in)
  );
  logic iso_s;
  logic dir_s;
  assign iso_s = sync_in[1];
  assign dir_s = sync_in[0];

  // Strap capture: held in reset, taken a few edges after release once the
  // synchroniser carries real pin values, then frozen.
  logic [1:0] cap_cnt_ff;
  logic [1:0] nxt_cap_cnt;
  logic       latched_ff;
  logic       nxt_latched;
  prc_mode_t  mode_ff;
  prc_mode_t  nxt_mode;

  always_comb begin
    nxt_cap_cnt = cap_cnt_ff;
    nxt_latched = latched_ff;
    nxt_mode    = mode_ff;
    if (i_rst) begin
      nxt_cap_cnt = 2'h0;
      nxt_latched = 1'b0;
      nxt_mode    = prc_mode_t'(`PRC_MODE_RESET);
    end else if (!latched_ff) begin
      if (cap_cnt_ff == `PRC_STRAP_SETTLE) begin
        nxt_mode    = prc_mode_t'(sync_in[3:2]);
        nxt_latched = 1'b1;
      end else begin
        nxt_cap_cnt = cap_cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    cap_cnt_ff <= nxt_cap_cnt;
    latched_ff <= nxt_latched;
    mode_ff    <= nxt_mode;
  end

  // Reference clock generation by division of the system clock. Halving the
  // system clock gives the reference with an even duty cycle, at the cost of
  // tying the reference frequency to the system clock.
  logic clk_div_ff;
  logic nxt_clk_div;
  always_comb begin
    nxt_clk_div = ~clk_div_ff;
    if (i_rst) begin
      nxt_clk_div = 1'b0;
    end
  end
  always_ff @(posedge i_clock) begin
    clk_div_ff <= nxt_clk_div;
  end

  // Pad decode. Every pad enable is registered so the pins never glitch while
  // the synchronised controls settle, which costs one cycle of latency.
  prc_pad_t pad_ff;
  prc_pad_t nxt_pad;
  logic     clk_out_ff;
  logic     nxt_clk_out;

  always_comb begin
    nxt_pad     = '{out_en: 1'b0, in_en: 1'b0, pulldown_en: 1'b0};
    nxt_clk_out = 1'b0;
    if (!i_rst && latched_ff) begin
      case (mode_ff)
        PRC_MII_MAC: begin
          nxt_pad = '{out_en: 1'b0, in_en: 1'b1, pulldown_en: 1'b1};
        end
        PRC_MII_PHY: begin
          nxt_pad.out_en = ~iso_s;
          nxt_clk_out    = clk_div_ff;
        end
        PRC_RMII_MAC, PRC_RMII_PHY: begin
          if (dir_s) begin
            nxt_clk_out = clk_div_ff;
            nxt_pad     = '{out_en: 1'b1, in_en: 1'b0, pulldown_en: 1'b0};
            if (mode_ff == PRC_RMII_PHY && iso_s) begin
              nxt_pad.out_en = 1'b0;
            end
          end else begin
            nxt_pad = '{out_en: 1'b0, in_en: 1'b1, pulldown_en: 1'b1};
            if (mode_ff == PRC_RMII_PHY && iso_s) begin
              nxt_pad = '{out_en: 1'b0, in_en: 1'b0, pulldown_en: 1'b0};
            end
          end
        end
        default: begin
          nxt_pad = '{out_en: 1'b0, in_en: 1'b0, pulldown_en: 1'b0};
        end
      endcase
    end
    // A pin that is not driven keeps a quiet low value, so a later enable
    // always starts the clock from a clean phase.
    nxt_clk_out = nxt_clk_out & nxt_pad.out_en;
  end

  always_ff @(posedge i_clock) begin
    pad_ff     <= nxt_pad;
    clk_out_ff <= nxt_clk_out;
  end

  // Link-clock heartbeat. The system side owns a one-bit token and flips it
  // each time the link side hands the current value back, so a running input
  // clock keeps the token circling and a stopped one freezes it.
  // The round trip is two link edges to cross in, one to register, and two
  // system edges to cross back, so the idle limit must outlast that even for
  // a slow link clock; a narrower counter would drop alive between returns.
  logic tok_ff;
  logic nxt_tok;
  logic tok_link;

  // The link side has no reset of its own: i_rst may come and go between two
  // link edges. It only copies the token, so it settles to a known value three
  // edges after the link clock starts, whatever state it woke up in.
  prc_sync #(.W(1)) u_tok_sync (
    .i_clock (i_port0_link_clock),
    .i_rst   (1'b0),
    .i_async (tok_ff),
    .o_sync  (tok_link)
  );

  logic hb_link_ff;
  logic nxt_hb_link;
  always_comb begin
    nxt_hb_link = tok_link;
  end
  always_ff @(posedge i_port0_link_clock) begin
    hb_link_ff <= nxt_hb_link;
  end

  logic hb_sync;
  prc_sync #(.W(1)) u_hb_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (hb_link_ff),
    .o_sync  (hb_sync)
  );

  logic [`PRC_HEARTBEAT_W-1:0] idle_ff;
  logic [`PRC_HEARTBEAT_W-1:0] nxt_idle;
  logic                        alive_ff;
  logic                        nxt_alive;

  // A return counts only once the strap capture has run, because until then
  // the back synchroniser still shows its reset zero, which would match a
  // freshly reset token and fake a live clock.
  always_comb begin
    nxt_tok   = tok_ff;
    nxt_idle  = idle_ff;
    nxt_alive = alive_ff;
    if (i_rst) begin
      nxt_tok   = 1'b0;
      nxt_idle  = '1;
      nxt_alive = 1'b0;
    end else if (latched_ff && hb_sync == tok_ff) begin
      nxt_tok   = ~tok_ff;
      nxt_idle  = '0;
      nxt_alive = 1'b1;
    end else if (idle_ff != '1) begin
      nxt_idle = idle_ff + `PRC_HEARTBEAT_W'(1);
    end else begin
      nxt_alive = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    tok_ff   <= nxt_tok;
    idle_ff  <= nxt_idle;
    alive_ff <= nxt_alive;
  end

  // Every output is a register; these lines only carry them onto the ports.
  assign o_port0_clk_out    = clk_out_ff;
  assign o_port0_clk_oe     = pad_ff.out_en;
  assign o_port0_clk_in_en  = pad_ff.in_en;
  assign o_port0_clk_pd_en  = pad_ff.pulldown_en;
  assign o_mode             = mode_ff;
  assign o_link_clock_alive = alive_ff;
endmodule
`default_nettype wire

// File: tb/prc_port0_refclk_select_chk.sv
// Assertions on the port pins of the port 0 clock pin select block.
`timescale 1ns/1ps
`default_nettype none
module prc_port0_refclk_select_chk
  import prc_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_virtual_phy_isolate,
  input wire logic       i_rmii_clock_dir_out,
  input wire logic       o_port0_clk_out,
  input wire logic       o_port0_clk_oe,
  input wire logic       o_port0_clk_in_en,
  input wire logic       o_port0_clk_pd_en,
  input wire logic [1:0] o_mode
);
  logic [2:0] iso_q;
  logic [2:0] dir_q;
  logic [3:0] age_ff;
  wire        p = iso_q[2] && o_mode == 2'h3;
  // Controls pass two sync flops and a register, so pads see them three edges late.
  always_ff @(posedge i_clock) begin
    iso_q  <= {iso_q[1:0], i_virtual_phy_isolate};
    dir_q  <= {dir_q[1:0], i_rmii_clock_dir_out};
    age_ff <= i_rst ? 4'h0 : age_ff + {3'h0, age_ff != 4'hF};
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Pads are only meaningful from the fifth edge after reset, once the straps
  // have been captured and decoded.
  sequence s_held;
    o_mode == $past(o_mode) && age_ff >= 4'h4;
  endsequence
  a_mac_input: assert property (s_held ##0 o_mode == 2'h0 |-> !o_port0_clk_oe && o_port0_clk_in_en)
    else $error("clock pin not an input in MII MAC mode");
  a_phy_isolate: assert property (s_held ##0 o_mode == 2'h1 |-> o_port0_clk_oe == !iso_q[2])
    else $error("MII PHY driver does not follow isolate");
  a_rmii_dir: assert property (s_held ##0 o_mode[1] |-> o_port0_clk_oe == (dir_q[2] && !p))
    else $error("RMII driver enable wrong");
  a_rmii_in: assert property (s_held ##0 o_mode[1] |-> o_port0_clk_in_en == (!dir_q[2] && !p))
    else $error("RMII input buffer enable wrong");
  a_pd_in: assert property (o_port0_clk_pd_en == o_port0_clk_in_en)
    else $error("pull-down differs from input buffer");
  a_clk_toggle: assert property (o_port0_clk_oe && $past(o_port0_clk_oe) |-> $changed(o_port0_clk_out))
    else $error("driven clock not at half system rate");
  a_idle_low: assert property (!o_port0_clk_oe |-> !o_port0_clk_out)
    else $error("clock value moves while not driven");
  a_mode_held: assert property (!$stable(o_mode) |-> age_ff < 4'h8)
    else $error("mode changed long after reset");
endmodule
bind prc_port0_refclk_select prc_port0_refclk_select_chk u_chk (.*);
`default_nettype wire

// File: tb/prc_link_partner.sv
// External party driving the RMII reference clock into the pin.
`timescale 1ns/1ps
`default_nettype none
module prc_link_partner (
  input  wire logic i_run,
  output logic      o_clk
);
  // Stopped clock rests low, as the pin's pull-down would leave it.
  initial begin
    o_clk = 1'b0;
    #37;
    forever begin
      #80;
      o_clk = i_run ? ~o_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/prc_port0_refclk_select_tb_top.sv
// Self-checking bench for the port 0 clock pin select block.
`timescale 1ns/1ps
`default_nettype none
module prc_port0_refclk_select_tb_top;
  import prc_pkg::*;
  logic clk, rst, lclk, b0, b1, iso, dir, run, out, oe, ien, pd, alive, t;
  logic [1:0] mode;
  int num_errors = 0;
  int comparisons = 0;
  prc_link_partner PHY (.i_run(run), .o_clk(lclk));
  prc_port0_refclk_select DUT (.i_clock(clk), .i_rst(rst), .i_port0_link_clock(lclk),
    .i_port0_mode_strap_bit0(b0), .i_port0_mode_strap_bit1(b1),
    .i_virtual_phy_isolate(iso), .i_rmii_clock_dir_out(dir), .o_port0_clk_out(out),
    .o_port0_clk_oe(oe), .o_port0_clk_in_en(ien), .o_port0_clk_pd_en(pd),
    .o_mode(mode), .o_link_clock_alive(alive));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [2:0] s, input logic [2:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Late strap changes must not reach the latched mode.
  task automatic boot(input logic [1:0] m);
    @(negedge clk);
    {b1, b0} = m;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk("mode", {1'b0, mode}, {1'b0, m});
    {b1, b0} = ~m;
    repeat (8) @(negedge clk);
    chk("held", {1'b0, mode}, {1'b0, m});
  endtask
  task automatic pads(input logic [1:0] m, input logic i, input logic d);
    logic eo, ei, p;
    p  = i && m == 2'h3;
    eo = m == 2'h0 ? 1'b0 : m == 2'h1 ? !i : d && !p;
    ei = m == 2'h0 ? 1'b1 : m[1] && !d && !p;
    iso = i;
    dir = d;
    repeat (5) @(negedge clk);
    chk("pads", {oe, ien, pd}, {eo, ei, ei});
    t = out;
    @(negedge clk);
    chk("clk", {2'h0, out}, {2'h0, eo & ~t});
  endtask
  task automatic link_alive();
    repeat (40) @(negedge clk);
    chk("alive", {2'h0, alive}, 3'h1);
    run = 1'b0;
    repeat (120) @(negedge clk);
    chk("dead", {2'h0, alive}, 3'h0);
    run = 1'b1;
  endtask
  initial begin
    {rst, b0, b1, iso, dir, run} = 6'h21;
    for (int m = 0; m < 4; m++) begin
      boot(m[1:0]);
      for (int k = 0; k < 4; k++) pads(m[1:0], k[1], k[0]);
    end
    link_alive();
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
